//--- hw/lbst_cfg.svh
// Purpose: Constants for the bank state tracker link and both ends
// Assumes: Timing counts are in link clock periods
// Notes: Plain defaults; adjust per speed grade
`ifndef LBST_CFG_SVH
`define LBST_CFG_SVH
`define LBST_NUM_BANKS 8
`define LBST_BA_W 3
`define LBST_TMR_W 8
`define LBST_IN_W 12
`define LBST_DIV_W 2
`define LBST_DIV_LAST 2'h3
`define LBST_SYNC_RST 12'h400
`define LBST_T_RCD 8'h04
`define LBST_T_RP 8'h04
`define LBST_T_RFCPB 8'h0a
`define LBST_T_RFCAB 8'h14
`define LBST_T_MRR 8'h04
`define LBST_T_MRW 8'h06
`define LBST_T_XP 8'h03
`define LBST_T_XSR 8'h06
`define LBST_T_BURST 8'h08
`define LBST_T_MPC 8'h02
`define LBST_T_SRE 8'h01
`endif

//--- hw/lbst_pkg.sv
// Purpose: Types shared by both ends of the bank state tracker
// Assumes: Commands are abstract codes, not the pin encoding
// Notes: Binary codes written out
package lbst_pkg;
	typedef enum logic [3:0] {
		CMD_DES = 4'h0, CMD_NOP = 4'h1, CMD_ACT = 4'h2, CMD_RD = 4'h3,
		CMD_WR = 4'h4, CMD_MWR = 4'h5, CMD_PRE = 4'h6, CMD_REF = 4'h7,
		CMD_MRW = 4'h8, CMD_MRR = 4'h9, CMD_MPC = 4'ha, CMD_SRE = 4'hb,
		CMD_SRX = 4'hc
	} lbst_cmd_t;
	typedef enum logic [3:0] {
		BS_IDLE = 4'h0, BS_ACTG = 4'h1, BS_ACTIVE = 4'h2, BS_READ = 4'h3,
		BS_WRITE = 4'h4, BS_RD_AP = 4'h5, BS_WR_AP = 4'h6, BS_PRECH = 4'h7,
		BS_REF_PB = 4'h8, BS_REF_AB = 4'h9, BS_MRR_I = 4'ha, BS_MRR_A = 4'hb,
		BS_MRW_I = 4'hc
	} lbst_bank_t;
	typedef enum logic [2:0] {
		DEV_NORM = 3'h0, DEV_IPD = 3'h1, DEV_APD = 3'h2, DEV_SREF = 3'h3, DEV_SPD = 3'h4
	} lbst_dev_t;
endpackage

//--- hw/lbst_if.sv
// Purpose: Link between memory controller end and memory device end
// Assumes: Controller makes link_clk; all other controller lines change on its falling edge
// Notes: Data lines reduced to drive and termination indications
`timescale 1ns/100ps
`include "lbst_cfg.svh"
interface lbst_if;
	logic link_clk;
	logic cke;
	logic odt;
	lbst_pkg::lbst_cmd_t cmd;
	logic [`LBST_BA_W-1:0] ba;
	logic ap;
	logic ab;
	logic dq_oe;
	logic dq_term;
	modport dev (input link_clk, input cke, input odt, input cmd, input ba, input ap,
		input ab, output dq_oe, output dq_term);
	modport host (output link_clk, output cke, output odt, output cmd, output ba,
		output ap, output ab, input dq_oe, input dq_term);
endinterface

//--- hw/lbst_device.sv
// Purpose: Memory device end; tracks per-bank state and checks commands
// Assumes: All link inputs foreign to ref_clk; link_clk well below ref_clk/4
// Notes: Illegal commands are dropped and flagged on cmd_err_ff
`timescale 1ns/100ps
`include "lbst_cfg.svh"
module lbst_device #(
	parameter int NB = `LBST_NUM_BANKS
) (
	input wire logic ref_clk,
	input wire logic rstn,
	lbst_if.dev lnk,
	output logic cmd_err_ff,
	output logic all_idle_ff,
	output logic pd_ff,
	output logic sref_ff,
	output logic [NB-1:0] bank_open_ff
);
	logic [`LBST_IN_W-1:0] s1_ff;
	logic [`LBST_IN_W-1:0] s2_ff;
	logic lclk_prev_ff;
	logic cke_prev_ff;
	logic cke_edge_ff;
	logic chg_ff;
	logic [`LBST_TMR_W-1:0] xw_ff;
	lbst_pkg::lbst_dev_t dev_ff;
	lbst_pkg::lbst_bank_t bst_ff [NB];
	logic [`LBST_TMR_W-1:0] tmr_ff [NB];
	logic dq_oe_ff;
	logic dq_term_ff;
	logic s_lclk, s_cke, s_odt, s_ap, s_ab;
	lbst_pkg::lbst_cmd_t s_cmd;
	logic [`LBST_BA_W-1:0] s_ba;
	logic lk_rise, cke_fall, cke_rise, go, legal, accept, quiet, sref;
	logic all_idle, all_pre_ok, any_open, any_read, locked;
	logic [NB-1:0] hit;
	lbst_pkg::lbst_bank_t nxt_bst [NB];
	logic [`LBST_TMR_W-1:0] nxt_tmr [NB];

	// Every link line, clock enable too, crosses as a plain level
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			// Enable idles high; a low reset value would fake a wake edge
			s1_ff <= `LBST_SYNC_RST;
			s2_ff <= `LBST_SYNC_RST;
		end else begin
			s1_ff <= {lnk.link_clk, lnk.cke, lnk.odt, lnk.cmd, lnk.ba, lnk.ap, lnk.ab};
			s2_ff <= s1_ff;
		end
	end
	assign s_lclk = s2_ff[11];
	assign s_cke = s2_ff[10];
	assign s_odt = s2_ff[9];
	assign s_cmd = lbst_pkg::lbst_cmd_t'(s2_ff[8:5]);
	assign s_ba = s2_ff[4:2];
	assign s_ap = s2_ff[1];
	assign s_ab = s2_ff[0];

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			lclk_prev_ff <= 1'b0;
			cke_prev_ff <= 1'b1;
		end else begin
			lclk_prev_ff <= s_lclk;
			cke_prev_ff <= s_cke;
		end
	end
	assign lk_rise = s_lclk & ~lclk_prev_ff;
	assign cke_fall = cke_prev_ff & ~s_cke;
	assign cke_rise = ~cke_prev_ff & s_cke;
	assign quiet = (s_cmd == lbst_pkg::CMD_DES) || (s_cmd == lbst_pkg::CMD_NOP);
	assign sref = (dev_ff == lbst_pkg::DEV_SREF);

	// Enable level at the previous link edge, and a pending change flag
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			cke_edge_ff <= 1'b0;
			chg_ff <= 1'b0;
		end else begin
			if (lk_rise)
				cke_edge_ff <= s_cke;
			// Set wins over the clear at the link edge
			if (cke_fall || cke_rise)
				chg_ff <= 1'b1;
			else if (lk_rise)
				chg_ff <= 1'b0;
		end
	end

	// Exit time, counted in link edges so the clock must really toggle
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			xw_ff <= '0;
		end else if (cke_rise) begin
			xw_ff <= `LBST_T_XP;
		end else if (lk_rise && accept && s_cmd == lbst_pkg::CMD_SRX) begin
			xw_ff <= `LBST_T_XSR;
		end else if (lk_rise && xw_ff != '0) begin
			xw_ff <= xw_ff - 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			dev_ff <= lbst_pkg::DEV_NORM;
		end else if (cke_fall) begin
			case (dev_ff)
				lbst_pkg::DEV_NORM: dev_ff <= any_open ? lbst_pkg::DEV_APD : lbst_pkg::DEV_IPD;
				lbst_pkg::DEV_SREF: dev_ff <= lbst_pkg::DEV_SPD;
				default: dev_ff <= dev_ff;
			endcase
		end else if (cke_rise) begin
			case (dev_ff)
				lbst_pkg::DEV_IPD, lbst_pkg::DEV_APD: dev_ff <= lbst_pkg::DEV_NORM;
				lbst_pkg::DEV_SPD: dev_ff <= lbst_pkg::DEV_SREF;
				default: dev_ff <= dev_ff;
			endcase
		end else if (lk_rise && accept && s_cmd == lbst_pkg::CMD_SRE) begin
			dev_ff <= lbst_pkg::DEV_SREF;
		end else if (lk_rise && accept && s_cmd == lbst_pkg::CMD_SRX) begin
			dev_ff <= lbst_pkg::DEV_NORM;
		end
	end

	// Bank summaries
	always_comb begin
		all_idle = 1'b1;
		all_pre_ok = 1'b1;
		any_open = 1'b0;
		any_read = 1'b0;
		locked = 1'b0;
		for (int i = 0; i < NB; i++) begin
			if (bst_ff[i] != lbst_pkg::BS_IDLE)
				all_idle = 1'b0;
			if (!(bst_ff[i] inside {lbst_pkg::BS_IDLE, lbst_pkg::BS_ACTIVE,
				lbst_pkg::BS_READ, lbst_pkg::BS_WRITE}))
				all_pre_ok = 1'b0;
			if (bst_ff[i] inside {lbst_pkg::BS_ACTG, lbst_pkg::BS_ACTIVE,
				lbst_pkg::BS_READ, lbst_pkg::BS_WRITE, lbst_pkg::BS_MRR_A})
				any_open = 1'b1;
			if (bst_ff[i] inside {lbst_pkg::BS_READ, lbst_pkg::BS_RD_AP})
				any_read = 1'b1;
			if (bst_ff[i] inside {lbst_pkg::BS_REF_PB, lbst_pkg::BS_REF_AB,
				lbst_pkg::BS_MRR_I, lbst_pkg::BS_MRR_A, lbst_pkg::BS_MRW_I})
				locked = 1'b1;
		end
	end

	// Legality looks at the addressed bank; all-bank PRE/REF, MRW and SRE check every bank, and any locked bank blocks all but DES/NOP
	always_comb begin
		lbst_pkg::lbst_bank_t st;
		st = bst_ff[s_ba];
		case (s_cmd)
			lbst_pkg::CMD_DES, lbst_pkg::CMD_NOP: legal = 1'b1;
			lbst_pkg::CMD_ACT: legal = !sref && st == lbst_pkg::BS_IDLE;
			lbst_pkg::CMD_RD, lbst_pkg::CMD_WR, lbst_pkg::CMD_MWR:
				legal = !sref && (st inside {lbst_pkg::BS_ACTIVE, lbst_pkg::BS_READ,
					lbst_pkg::BS_WRITE});
			lbst_pkg::CMD_PRE:
				legal = !sref && (s_ab ? all_pre_ok : (st inside {lbst_pkg::BS_IDLE,
					lbst_pkg::BS_ACTIVE, lbst_pkg::BS_READ, lbst_pkg::BS_WRITE}));
			lbst_pkg::CMD_REF: legal = !sref && (s_ab ? all_idle : st == lbst_pkg::BS_IDLE);
			lbst_pkg::CMD_MRW: legal = all_idle;
			lbst_pkg::CMD_MRR, lbst_pkg::CMD_MPC: legal = 1'b1;
			lbst_pkg::CMD_SRE: legal = !sref && all_idle;
			lbst_pkg::CMD_SRX: legal = sref;
			default: legal = 1'b0;
		endcase
		if (locked && !quiet)
			legal = 1'b0;
	end

	assign go = lk_rise && s_cke && cke_edge_ff && xw_ff == '0 && !chg_ff;
	assign accept = go && legal && !quiet;

	// Next state of each bank hit by the accepted command
	always_comb begin
		for (int i = 0; i < NB; i++) begin
			hit[i] = 1'b0;
			nxt_bst[i] = bst_ff[i];
			nxt_tmr[i] = tmr_ff[i];
			case (s_cmd)
				lbst_pkg::CMD_ACT: begin
					hit[i] = (s_ba == i[`LBST_BA_W-1:0]);
					nxt_bst[i] = lbst_pkg::BS_ACTG;
					nxt_tmr[i] = `LBST_T_RCD;
				end
				lbst_pkg::CMD_RD, lbst_pkg::CMD_WR, lbst_pkg::CMD_MWR: begin
					hit[i] = (s_ba == i[`LBST_BA_W-1:0]);
					if (s_cmd == lbst_pkg::CMD_RD)
						nxt_bst[i] = s_ap ? lbst_pkg::BS_RD_AP : lbst_pkg::BS_READ;
					else
						nxt_bst[i] = s_ap ? lbst_pkg::BS_WR_AP : lbst_pkg::BS_WRITE;
					nxt_tmr[i] = s_ap ? `LBST_T_BURST + `LBST_T_RP : `LBST_T_BURST;
				end
				lbst_pkg::CMD_PRE: begin
					hit[i] = s_ab || (s_ba == i[`LBST_BA_W-1:0]);
					nxt_bst[i] = lbst_pkg::BS_PRECH;
					nxt_tmr[i] = `LBST_T_RP;
				end
				lbst_pkg::CMD_REF: begin
					hit[i] = s_ab || (s_ba == i[`LBST_BA_W-1:0]);
					nxt_bst[i] = s_ab ? lbst_pkg::BS_REF_AB : lbst_pkg::BS_REF_PB;
					nxt_tmr[i] = s_ab ? `LBST_T_RFCAB : `LBST_T_RFCPB;
				end
				lbst_pkg::CMD_MRR: begin
					// Banks in transition keep their own timers
					hit[i] = bst_ff[i] inside {lbst_pkg::BS_IDLE, lbst_pkg::BS_ACTIVE};
					nxt_bst[i] = (bst_ff[i] == lbst_pkg::BS_IDLE) ? lbst_pkg::BS_MRR_I
						: lbst_pkg::BS_MRR_A;
					nxt_tmr[i] = `LBST_T_MRR;
				end
				lbst_pkg::CMD_MRW: begin
					hit[i] = 1'b1;
					nxt_bst[i] = lbst_pkg::BS_MRW_I;
					nxt_tmr[i] = `LBST_T_MRW;
				end
				default: hit[i] = 1'b0;
			endcase
		end
	end

	function automatic lbst_pkg::lbst_bank_t done_st(input lbst_pkg::lbst_bank_t st);
		case (st)
			lbst_pkg::BS_ACTG, lbst_pkg::BS_READ, lbst_pkg::BS_WRITE,
			lbst_pkg::BS_MRR_A: done_st = lbst_pkg::BS_ACTIVE;
			default: done_st = lbst_pkg::BS_IDLE;
		endcase
	endfunction

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < NB; i++) begin
				bst_ff[i] <= lbst_pkg::BS_IDLE;
				tmr_ff[i] <= '0;
			end
		end else if (lk_rise) begin
			for (int i = 0; i < NB; i++) begin
				if (accept && hit[i]) begin
					bst_ff[i] <= nxt_bst[i];
					tmr_ff[i] <= nxt_tmr[i];
				end else if (tmr_ff[i] == `LBST_TMR_W'(1)) begin
					bst_ff[i] <= done_st(bst_ff[i]);
					tmr_ff[i] <= '0;
				end else if (tmr_ff[i] != '0) begin
					tmr_ff[i] <= tmr_ff[i] - 1'b1;
				end
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			cmd_err_ff <= 1'b0;
		end else begin
			cmd_err_ff <= (go && !legal)
				|| (lk_rise && chg_ff && s_cmd != lbst_pkg::CMD_DES)
				|| (lk_rise && s_cke && xw_ff != '0 && !quiet);
		end
	end

	// Power-down lets termination, not drivers, own the data lines
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			dq_oe_ff <= 1'b0;
			dq_term_ff <= 1'b0;
			pd_ff <= 1'b0;
			sref_ff <= 1'b0;
			all_idle_ff <= 1'b1;
			bank_open_ff <= '0;
		end else begin
			pd_ff <= dev_ff inside {lbst_pkg::DEV_IPD, lbst_pkg::DEV_APD, lbst_pkg::DEV_SPD};
			dq_oe_ff <= (dev_ff == lbst_pkg::DEV_NORM) && any_read;
			dq_term_ff <= (dev_ff inside {lbst_pkg::DEV_IPD, lbst_pkg::DEV_APD,
				lbst_pkg::DEV_SPD}) && s_odt;
			sref_ff <= (dev_ff == lbst_pkg::DEV_SREF) || (dev_ff == lbst_pkg::DEV_SPD);
			all_idle_ff <= all_idle;
			for (int i = 0; i < NB; i++)
				bank_open_ff[i] <= bst_ff[i] inside {lbst_pkg::BS_ACTIVE, lbst_pkg::BS_READ,
					lbst_pkg::BS_WRITE, lbst_pkg::BS_MRR_A};
		end
	end
	assign lnk.dq_oe = dq_oe_ff;
	assign lnk.dq_term = dq_term_ff;
endmodule // lbst_device

//--- hw/lbst_host.sv
// Purpose: Controller end; makes the link clock and issues legal commands only
// Assumes: User holds req_valid until ack or reject
// Notes: One command at a time, each waited out in full; slow but always legal
`timescale 1ns/100ps
`include "lbst_cfg.svh"
module lbst_host #(
	parameter int NB = `LBST_NUM_BANKS
) (
	input wire logic ref_clk,
	input wire logic rstn,
	lbst_if.host lnk,
	input wire logic req_valid,
	input wire lbst_pkg::lbst_cmd_t req_cmd,
	input wire logic [`LBST_BA_W-1:0] req_ba,
	input wire logic req_ap,
	input wire logic req_ab,
	input wire logic cke_req,
	input wire logic odt_req,
	output logic req_ack_ff,
	output logic req_rej_ff,
	output logic busy_ff
);
	logic [`LBST_DIV_W-1:0] div_ff;
	logic lclk_ff;
	logic cke_ff;
	logic odt_ff;
	lbst_pkg::lbst_cmd_t cmd_ff;
	logic [`LBST_BA_W-1:0] ba_ff;
	logic ap_ff;
	logic ab_ff;
	logic [`LBST_TMR_W-1:0] wait_ff;
	logic [NB-1:0] open_ff;
	logic hsref_ff;
	logic tick, ok, take;
	logic [`LBST_TMR_W-1:0] dur;

	// Divider; tick marks the falling link edge where lines may change
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			div_ff <= '0;
			lclk_ff <= 1'b0;
		end else begin
			div_ff <= div_ff + 1'b1;
			if (div_ff == `LBST_DIV_LAST)
				lclk_ff <= ~lclk_ff;
		end
	end
	assign tick = (div_ff == `LBST_DIV_LAST) && lclk_ff;
	assign take = tick && wait_ff == '0 && cke_ff && cke_ff == cke_req && req_valid;

	always_comb begin
		case (req_cmd)
			lbst_pkg::CMD_ACT: ok = !hsref_ff && !open_ff[req_ba];
			lbst_pkg::CMD_RD, lbst_pkg::CMD_WR, lbst_pkg::CMD_MWR:
				ok = !hsref_ff && open_ff[req_ba];
			lbst_pkg::CMD_PRE: ok = !hsref_ff;
			lbst_pkg::CMD_REF: ok = !hsref_ff && (req_ab ? open_ff == '0 : !open_ff[req_ba]);
			lbst_pkg::CMD_MRW: ok = open_ff == '0;
			lbst_pkg::CMD_MRR, lbst_pkg::CMD_MPC, lbst_pkg::CMD_NOP: ok = 1'b1;
			lbst_pkg::CMD_SRE: ok = !hsref_ff && open_ff == '0;
			lbst_pkg::CMD_SRX: ok = hsref_ff;
			default: ok = 1'b0;
		endcase
		case (req_cmd)
			lbst_pkg::CMD_ACT: dur = `LBST_T_RCD;
			lbst_pkg::CMD_RD, lbst_pkg::CMD_WR, lbst_pkg::CMD_MWR:
				dur = req_ap ? `LBST_T_BURST + `LBST_T_RP : `LBST_T_BURST;
			lbst_pkg::CMD_PRE: dur = `LBST_T_RP;
			lbst_pkg::CMD_REF: dur = req_ab ? `LBST_T_RFCAB : `LBST_T_RFCPB;
			lbst_pkg::CMD_MRR: dur = `LBST_T_MRR;
			lbst_pkg::CMD_MRW: dur = `LBST_T_MRW;
			lbst_pkg::CMD_SRX: dur = `LBST_T_XSR;
			lbst_pkg::CMD_MPC: dur = `LBST_T_MPC;
			default: dur = `LBST_T_SRE;
		endcase
	end

	// Enable changes only in an otherwise quiet link period
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			cke_ff <= 1'b1;
			odt_ff <= 1'b0;
			cmd_ff <= lbst_pkg::CMD_DES;
			ba_ff <= '0;
			ap_ff <= 1'b0;
			ab_ff <= 1'b0;
			wait_ff <= '0;
		end else if (tick) begin
			odt_ff <= odt_req;
			cmd_ff <= lbst_pkg::CMD_DES;
			if (wait_ff != '0) begin
				wait_ff <= wait_ff - 1'b1;
			end else if (cke_ff != cke_req) begin
				cke_ff <= cke_req;
				if (cke_req)
					wait_ff <= `LBST_T_XP;
			end else if (take && ok) begin
				cmd_ff <= req_cmd;
				ba_ff <= req_ba;
				ap_ff <= req_ap;
				ab_ff <= req_ab;
				wait_ff <= dur;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			open_ff <= '0;
			hsref_ff <= 1'b0;
		end else if (take && ok) begin
			case (req_cmd)
				lbst_pkg::CMD_ACT: open_ff[req_ba] <= 1'b1;
				lbst_pkg::CMD_RD, lbst_pkg::CMD_WR, lbst_pkg::CMD_MWR:
					if (req_ap)
						open_ff[req_ba] <= 1'b0;
				lbst_pkg::CMD_PRE:
					if (req_ab)
						open_ff <= '0;
					else
						open_ff[req_ba] <= 1'b0;
				lbst_pkg::CMD_SRE: hsref_ff <= 1'b1;
				lbst_pkg::CMD_SRX: hsref_ff <= 1'b0;
				default: hsref_ff <= hsref_ff;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			req_ack_ff <= 1'b0;
			req_rej_ff <= 1'b0;
			busy_ff <= 1'b0;
		end else begin
			req_ack_ff <= take && ok;
			req_rej_ff <= take && !ok;
			busy_ff <= wait_ff != '0;
		end
	end
	assign lnk.link_clk = lclk_ff;
	assign lnk.cke = cke_ff;
	assign lnk.odt = odt_ff;
	assign lnk.cmd = cmd_ff;
	assign lnk.ba = ba_ff;
	assign lnk.ap = ap_ff;
	assign lnk.ab = ab_ff;
endmodule // lbst_host

//--- tb/lbst_properties.sv
// Purpose: Concurrent checks on the link joining host and device ends
// Assumes: Link lines are sampled by ref_clk like any foreign input
// Notes: Small counters stand in for long repetitions
`timescale 1ns/100ps
`include "lbst_cfg.svh"
module lbst_properties (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic link_clk,
	input wire logic cke,
	input wire logic odt,
	input wire lbst_pkg::lbst_cmd_t cmd,
	input wire logic [`LBST_BA_W-1:0] ba,
	input wire logic ap,
	input wire logic ab,
	input wire logic dq_oe,
	input wire logic dq_term
);
	logic [7:0] lo_cnt_ff, hi_cnt_ff, rise_cnt_ff;
	logic cke_q_ff, in_sref_ff;
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			lo_cnt_ff <= 8'h00;
			hi_cnt_ff <= 8'h00;
		end else begin
			lo_cnt_ff <= cke ? 8'h00 : lo_cnt_ff + {7'h00, lo_cnt_ff != 8'hff};
			hi_cnt_ff <= !cke ? 8'h00 : hi_cnt_ff + {7'h00, hi_cnt_ff != 8'hff};
		end
	end
	// Starts saturated so the first request after reset is not caught
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			cke_q_ff <= 1'b1;
			rise_cnt_ff <= 8'hff;
		end else begin
			cke_q_ff <= cke;
			if (cke && !cke_q_ff)
				rise_cnt_ff <= 8'h00;
			else if (rise_cnt_ff != 8'hff)
				rise_cnt_ff <= rise_cnt_ff + 8'h01;
		end
	end
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			in_sref_ff <= 1'b0;
		else if (cmd == lbst_pkg::CMD_SRE)
			in_sref_ff <= 1'b1;
		else if (cmd == lbst_pkg::CMD_SRX)
			in_sref_ff <= 1'b0;
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	a_cke_change_des: assert property ($changed(cke) |-> cmd == lbst_pkg::CMD_DES)
		else $error("cke moved with a command on the bus");
	a_exit_des_only: assert property (rise_cnt_ff < 8'h14 |-> cmd == lbst_pkg::CMD_DES)
		else $error("command too soon after power-down exit");
	a_link_high_four: assert property ($rose(link_clk) |-> link_clk [*4] ##1 !link_clk)
		else $error("link clock high phase not four cycles");
	a_cmd_on_fall: assert property ($changed(cmd) |-> $fell(link_clk))
		else $error("command changed off the link falling edge");
	a_cmd_held: assert property ($changed(cmd) && cmd != lbst_pkg::CMD_DES |=>
		$stable(cmd) [*7] ##1 cmd == lbst_pkg::CMD_DES)
		else $error("command not held one link period");
	a_pd_des_only: assert property (!cke |-> cmd == lbst_pkg::CMD_DES)
		else $error("command while clock enable low");
	a_sref_cmd_set: assert property (in_sref_ff |-> cmd inside {lbst_pkg::CMD_DES,
		lbst_pkg::CMD_NOP, lbst_pkg::CMD_SRE, lbst_pkg::CMD_SRX, lbst_pkg::CMD_MRR,
		lbst_pkg::CMD_MRW, lbst_pkg::CMD_MPC})
		else $error("bad command in self refresh");
	a_pd_dq_off: assert property (lo_cnt_ff == 8'h14 |-> !dq_oe && dq_term == odt)
		else $error("data lines wrong in power-down");
	a_awake_no_term: assert property (hi_cnt_ff == 8'h14 |-> !dq_term)
		else $error("termination left on after wake");
endmodule // lbst_properties

//--- tb/tb.sv
// Purpose: Self-checking bench for host and device ends of the tracker
// Assumes: Host waits each command out, so banks are idle or open between requests
// Notes: A second device faces a rule-breaking driver for error checks
`timescale 1ns/100ps
`include "lbst_cfg.svh"
module tb;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic req_valid = 1'b0;
	lbst_pkg::lbst_cmd_t req_cmd = lbst_pkg::CMD_NOP;
	logic [2:0] req_ba = 3'h0;
	logic req_ap = 1'b0;
	logic req_ab = 1'b0;
	logic cke_req = 1'b1;
	logic odt_req = 1'b0;
	logic req_ack_ff, req_rej_ff, busy_ff, cmd_err_ff, all_idle_ff, pd_ff, sref_ff, err_b;
	logic [7:0] bank_open_ff;
	logic [7:0] open_m = 8'h00;
	logic sref_m = 1'b0;
	logic saw_oe = 1'b0;
	logic [31:0] seed = 32'h2c;
	lbst_pkg::lbst_cmd_t pick [8];
	int miscompares = 0;
	int check_count = 0;
	int err_a = 0;
	int err_bn = 0;
	int cyc = 0;
	lbst_if lnk();
	lbst_if lnk_b();
	always #20 ref_clk = ~ref_clk;
	lbst_host i_lbst_host (.ref_clk(ref_clk), .rstn(rstn), .lnk(lnk), .req_valid(req_valid),
		.req_cmd(req_cmd), .req_ba(req_ba), .req_ap(req_ap), .req_ab(req_ab), .cke_req(cke_req),
		.odt_req(odt_req), .req_ack_ff(req_ack_ff), .req_rej_ff(req_rej_ff), .busy_ff(busy_ff));
	lbst_device i_lbst_device (.ref_clk(ref_clk), .rstn(rstn), .lnk(lnk), .cmd_err_ff(cmd_err_ff),
		.all_idle_ff(all_idle_ff), .pd_ff(pd_ff), .sref_ff(sref_ff), .bank_open_ff(bank_open_ff));
	lbst_device i_lbst_device_b (.ref_clk(ref_clk), .rstn(rstn), .lnk(lnk_b), .cmd_err_ff(err_b),
		.all_idle_ff(), .pd_ff(), .sref_ff(), .bank_open_ff());
	lbst_properties i_lbst_properties (.ref_clk(ref_clk), .rstn(rstn), .link_clk(lnk.link_clk),
		.cke(lnk.cke), .odt(lnk.odt), .cmd(lnk.cmd), .ba(lnk.ba), .ap(lnk.ap), .ab(lnk.ab),
		.dq_oe(lnk.dq_oe), .dq_term(lnk.dq_term));
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cmd_err_ff === 1'b1)
			err_a <= err_a + 1;
		if (err_b === 1'b1)
			err_bn <= err_bn + 1;
		if (lnk.dq_oe === 1'b1)
			saw_oe <= 1'b1;
		if (cyc == 60000) begin
			miscompares++;
			tally_and_finish();
		end
	end
	// Phase offset keeps the far link clock unrelated to ref_clk
	initial begin
		lnk_b.link_clk = 1'b0;
		#7;
		forever #160 lnk_b.link_clk = ~lnk_b.link_clk;
	end
	function automatic logic [31:0] xs(logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	function automatic logic legal_f(lbst_pkg::lbst_cmd_t c, logic [2:0] b, logic x);
		if (sref_m)
			return c inside {lbst_pkg::CMD_MRR, lbst_pkg::CMD_MRW, lbst_pkg::CMD_MPC,
				lbst_pkg::CMD_SRX};
		case (c)
			lbst_pkg::CMD_ACT: return !open_m[b];
			lbst_pkg::CMD_RD, lbst_pkg::CMD_WR, lbst_pkg::CMD_MWR: return open_m[b];
			lbst_pkg::CMD_REF: return x ? open_m == 8'h00 : !open_m[b];
			lbst_pkg::CMD_MRW, lbst_pkg::CMD_SRE: return open_m == 8'h00;
			lbst_pkg::CMD_PRE, lbst_pkg::CMD_MRR, lbst_pkg::CMD_NOP: return 1'b1;
			lbst_pkg::CMD_MPC: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction
	task automatic chk(logic [7:0] seen, logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic chk1(logic seen, logic exp);
		chk({7'h00, seen}, {7'h00, exp});
	endtask
	task automatic req(lbst_pkg::lbst_cmd_t c, logic [2:0] b, logic [1:0] ax);
		logic e;
		int n;
		e = legal_f(c, b, ax[0]);
		saw_oe = 1'b0;
		req_cmd = c;
		req_ba = b;
		{req_ap, req_ab} = ax;
		req_valid = 1'b1;
		n = 0;
		while (req_ack_ff !== 1'b1 && req_rej_ff !== 1'b1 && n < 300) begin
			@(negedge ref_clk);
			n++;
		end
		req_valid = 1'b0;
		chk1(req_ack_ff | req_rej_ff, 1'b1);
		chk1(req_ack_ff, e);
		if (e === 1'b1) begin
			case (c)
				lbst_pkg::CMD_ACT: open_m[b] = 1'b1;
				lbst_pkg::CMD_RD, lbst_pkg::CMD_WR, lbst_pkg::CMD_MWR: open_m[b] = open_m[b] & !ax[1];
				lbst_pkg::CMD_PRE: open_m = ax[0] ? 8'h00 : open_m & ~(8'h01 << b);
				lbst_pkg::CMD_SRE: sref_m = 1'b1;
				lbst_pkg::CMD_SRX: sref_m = 1'b0;
				default: ;
			endcase
		end
		repeat (2) @(negedge ref_clk);
		n = 0;
		while (busy_ff !== 1'b0 && n < 400) begin
			@(negedge ref_clk);
			n++;
		end
		chk1(busy_ff, 1'b0);
		repeat (24) @(negedge ref_clk);
		chk(bank_open_ff, open_m);
		chk1(all_idle_ff, open_m == 8'h00);
		chk1(sref_ff, sref_m);
		if (c == lbst_pkg::CMD_RD && e)
			chk1(saw_oe, 1'b1);
	endtask
	task automatic pdn(logic o);
		int n;
		odt_req = o;
		cke_req = 1'b0;
		n = 0;
		while (lnk.cke !== 1'b0 && n < 100) begin
			@(negedge ref_clk);
			n++;
		end
		repeat (40) @(negedge ref_clk);
		chk1(pd_ff, 1'b1);
		chk1(lnk.dq_oe, 1'b0);
		chk1(lnk.dq_term, o);
		cke_req = 1'b1;
		repeat (80) @(negedge ref_clk);
		chk1(pd_ff, 1'b0);
		chk(bank_open_ff, open_m);
		chk1(lnk.dq_term, 1'b0);
		odt_req = 1'b0;
	endtask
	task automatic drv_b(logic k, lbst_pkg::lbst_cmd_t c);
		@(negedge lnk_b.link_clk);
		lnk_b.cke = k;
		lnk_b.cmd = c;
		@(negedge lnk_b.link_clk);
		lnk_b.cmd = lbst_pkg::CMD_DES;
	endtask
	initial begin
		lbst_pkg::lbst_cmd_t c;
		{lnk_b.cke, lnk_b.odt, lnk_b.ba, lnk_b.ap, lnk_b.ab} = 7'h40;
		lnk_b.cmd = lbst_pkg::CMD_DES;
		pick = '{lbst_pkg::CMD_ACT, lbst_pkg::CMD_RD, lbst_pkg::CMD_WR, lbst_pkg::CMD_MWR,
			lbst_pkg::CMD_PRE, lbst_pkg::CMD_REF, lbst_pkg::CMD_MRR, lbst_pkg::CMD_ACT};
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		rstn = 1'b1;
		repeat (4) @(negedge ref_clk);
		req(lbst_pkg::CMD_ACT, 3'h2, 2'h0);
		req(lbst_pkg::CMD_ACT, 3'h2, 2'h0);
		req(lbst_pkg::CMD_REF, 3'h2, 2'h0);
		req(lbst_pkg::CMD_MRW, 3'h0, 2'h0);
		req(lbst_pkg::CMD_MRR, 3'h2, 2'h0);
		pdn(1'h1);
		req(lbst_pkg::CMD_WR, 3'h2, 2'h0);
		req(lbst_pkg::CMD_RD, 3'h2, 2'h2);
		req(lbst_pkg::CMD_PRE, 3'h5, 2'h0);
		req(lbst_pkg::CMD_REF, 3'h5, 2'h0);
		req(lbst_pkg::CMD_REF, 3'h0, 2'h1);
		req(lbst_pkg::CMD_MRW, 3'h0, 2'h0);
		req(lbst_pkg::CMD_ACT, 3'h6, 2'h0);
		req(lbst_pkg::CMD_PRE, 3'h0, 2'h1);
		pdn(1'h0);
		req(lbst_pkg::CMD_NOP, 3'h0, 2'h0);
		req(lbst_pkg::CMD_SRE, 3'h0, 2'h0);
		pdn(1'h1);
		req(lbst_pkg::CMD_ACT, 3'h1, 2'h0);
		req(lbst_pkg::CMD_MRR, 3'h0, 2'h0);
		req(lbst_pkg::CMD_MRW, 3'h0, 2'h0);
		req(lbst_pkg::CMD_MPC, 3'h0, 2'h0);
		req(lbst_pkg::CMD_SRX, 3'h0, 2'h0);
		for (int i = 0; i < 40; i++) begin
			seed = xs(seed);
			c = pick[seed[2:0]];
			req(c, seed[5:3], {seed[6], c inside {lbst_pkg::CMD_PRE, lbst_pkg::CMD_REF} && !seed[7]});
		end
		chk(err_a[7:0], 8'h00);
		drv_b(1'h0, lbst_pkg::CMD_ACT);
		repeat (24) @(negedge ref_clk);
		chk(err_bn[7:0], 8'h01);
		drv_b(1'h1, lbst_pkg::CMD_DES);
		drv_b(1'h1, lbst_pkg::CMD_ACT);
		repeat (24) @(negedge ref_clk);
		chk(err_bn[7:0], 8'h02);
		repeat (8) drv_b(1'h1, lbst_pkg::CMD_DES);
		drv_b(1'h1, lbst_pkg::CMD_SRE);
		drv_b(1'h1, lbst_pkg::CMD_DES);
		drv_b(1'h1, lbst_pkg::CMD_MRR);
		repeat (24) @(negedge ref_clk);
		chk(err_bn[7:0], 8'h02);
		drv_b(1'h1, lbst_pkg::CMD_ACT);
		repeat (24) @(negedge ref_clk);
		chk(err_bn[7:0], 8'h03);
		tally_and_finish();
	end
endmodule // tb
